//--- core/prl_consts.svh
// Purpose: constants for the pwm routing and lock block
// Assumes: 16-bit register frames, 50 MHz clock
// Notes:   frame address codes are bits 13..8
`ifndef PRL_CONSTS_SVH
`define PRL_CONSTS_SVH
`define PRL_ADDR_PWM1      6'h05
`define PRL_ADDR_PWM1_HI   4'h1
`define PRL_ADDR_ROUTE     6'h24
`define PRL_ADDR_GSEL      6'h11
`define PRL_ADDR_LOCK      6'h2a
`define PRL_ADDR_CLR       6'h31
`define PRL_ADDR_FPWM      6'h34
`define PRL_LOCK_CODE      3'h6
`define PRL_UNLOCK_CODE    3'h3
`define PRL_LOCK_RST       8'h60
`define PRL_PWM1_RST       10'h000
`define PRL_FPWM_RST       8'h80
`define PRL_DIV_1024       12'd1024
`define PRL_DIV_512        12'd512
`define PRL_DIV_256        12'd256
`define PRL_DIV_128        12'd128
`define PRL_DIV_64         12'd64
`define PRL_DIV_51         12'd51
`endif

//--- core/prl_pkg.sv
// Purpose: types for the pwm routing and lock block
// Assumes: nothing
// Notes:   frame kinds decoded from bits 15..14
package prl_pkg;
  typedef enum logic [1:0] {
    PRL_FR_IDLE,
    PRL_FR_WRITE,
    PRL_FR_READ,
    PRL_FR_BAD
  } prl_frame_t;
endpackage

//--- core/prl_gen.sv
// Purpose: one pwm generator with divider, range and duty
// Assumes: tick prescaler from divider code; period of 256 duty steps
// Notes:   code 11 holds output on
`timescale 1ns/10ps
`include "prl_consts.svh"
module prl_gen
  import prl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // settings
  input  wire logic       enable,
  input  wire logic [1:0] divider_sel,
  input  wire logic       range_sel,
  input  wire logic [7:0] duty,
  // output
  output logic            pwm
);
  typedef struct packed {
    logic [11:0] pre;
    logic [7:0]  step;
    logic        out;
  } prl_gen_st_t;
  prl_gen_st_t st, next_st;
  logic [11:0] div;

  // divider per code and range; 51.2 approximated by 51
  always_comb begin
    div = `PRL_DIV_1024;
    unique case (divider_sel)
      2'b00: div = range_sel ? `PRL_DIV_128 : `PRL_DIV_1024;
      2'b01: div = range_sel ? `PRL_DIV_64 : `PRL_DIV_512;
      2'b10: div = range_sel ? `PRL_DIV_51 : `PRL_DIV_256;
      2'b11: div = `PRL_DIV_256;
    endcase
  end

  always_comb begin
    next_st = st;
    if (!enable) begin // see (R15)
      next_st.pre  = 12'h000;
      next_st.step = 8'h00;
      next_st.out  = 1'b0;
    end else begin
      if (st.pre + 12'h001 >= div) begin // see (R1) (R14)
        next_st.pre  = 12'h000;
        next_st.step = st.step + 8'h01;
      end else begin
        next_st.pre = st.pre + 12'h001;
      end
      if (divider_sel == 2'b11) begin
        next_st.out = 1'b1; // see (R2)
      end else begin
        // on for duty of 256 steps: 0 off, ff gives 255/256 (see (R3) (R4) (R19))
        next_st.out = (next_st.step < duty);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign pwm = st.out;

  full_on_a: assert property (@(posedge clk) disable iff (rst)
    ce && enable && divider_sel == 2'b11 |=> pwm) else $error("code 11 not full on"); // see (R2)
  zero_off_a: assert property (@(posedge clk) disable iff (rst)
    ce && enable && duty == 8'h00 && divider_sel != 2'b11 |=> !pwm) else $error("zero duty not off"); // see (R3)
  gen_idle_a: assert property (@(posedge clk) disable iff (rst)
    ce && !enable |=> !pwm) else $error("disabled generator active"); // see (R15)
  max_on_a: assert property (@(posedge clk) disable iff (rst)
    ce && enable && duty == 8'hff && divider_sel != 2'b11 && next_st.step != 8'hff |=> pwm)
    else $error("max duty not on"); // see (R4) (R19)
  div_len_a: assert property (@(posedge clk) disable iff (rst)
    ce && enable |=> st.pre < $past(div)) else $error("prescaler past divider"); // see (R1) (R14)
endmodule

//--- core/prl_top.sv
// Purpose: pwm generator 1 setup, output routing and register lock
// Assumes: frames arrive whole as 16-bit words with a one-cycle strobe
// Notes:   read data stands until the next read
// Operation
// (R1) Divider code picks clock divide 1024, 512 or 256, high range 128, 64, 51.2; the code divides by 51 for 51.2.
// (R2) Divider code 11 holds generator output on at full duty.
// (R3) Duty zero keeps generator output off.
// (R4) Duty all ones gives 255 of 256 steps on.
// (R5) Route-enable bit per output hands it to a pwm generator; reset cleared.
// (R6) Generator-select bit per output: zero picks generator 0, one picks generator 1.
// (R7) Host must set route-enable too; select alone does not drive the output.
// (R8) Lock code 110 locks; then only lock field and clear bits accept writes.
// (R9) When unlocked, other lock codes do not lock.
// (R10) Unlock code 011 unlocks; other codes keep lock while locked.
// (R11) Overtemperature warning is read-only bit 2, reset zero.
// (R12) Bits 4 and 3 of the lock register are reserved, read-only.
// (R13) Bit 0 selects slew: zero slow rate, one fast rate.
// (R14) Range bit picks low or high base frequency set.
// (R15) Generator runs only while its enable bit is one.
// (R16) Writing one to an error-latch clear bit clears that output's latch.
// (R17) Frame: 10 in bits 15..14 writes, 01 reads, bits 13..8 address.
// (R18) Lock field resets to 011, registers start unlocked.
// (R19) Active time per period is duty over 256.
`timescale 1ns/10ps
`include "prl_consts.svh"
module prl_top
  import prl_pkg::*;
#(
  parameter int NOUT = 8
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  // register frame port
  input  wire logic            frame_valid,
  input  wire logic [15:0]     frame_data,
  output logic [15:0]          read_data,
  output logic                 read_valid,
  // status in
  input  wire logic            overtemp_event,
  input  wire logic            gen0_pwm,
  // outputs
  output logic [NOUT-1:0]      output_pwm_active,
  output logic [NOUT-1:0]      output_pwm_level,
  output logic [NOUT-1:0]      error_latch_clear,
  output logic                 slew_select,
  output logic                 gen1_pwm
);
  typedef struct packed {
    logic [1:0]      gen1_divider_sel;
    logic [7:0]      gen1_duty;
    logic            gen1_range_sel;
    logic            gen1_enable;
    logic [NOUT-1:0] output_route_enable;
    logic [NOUT-1:0] output_generator_sel;
    logic [2:0]      lock;
    logic            locked;
    logic            overtemp_warning_flag;
    logic            olmax;
    logic            slew;
    logic [NOUT-1:0] clr;
    logic [NOUT-1:0] act;
    logic [NOUT-1:0] lvl;
    logic [15:0]     rdata;
    logic            rvalid;
  } prl_st_t;
  prl_st_t st, next_st;
  logic gen1_raw;
  prl_frame_t kind;
  logic [5:0] addr;
  logic [7:0] wd;

  function automatic prl_frame_t frame_kind(input logic v, input logic [1:0] k);
    if (!v) return PRL_FR_IDLE;
    if (k == 2'b10) return PRL_FR_WRITE;
    if (k == 2'b01) return PRL_FR_READ;
    return PRL_FR_BAD;
  endfunction

  // pwm1 setup owns address bits 13..10 only; bits 9..8 carry its divider code
  function automatic logic pwm1_hit(input logic [5:0] a);
    return a[5:2] == `PRL_ADDR_PWM1_HI;
  endfunction

  prl_gen #(
  ) u_gen1 (
    .clk         (clk),
    .rst         (rst),
    .ce          (ce),
    .enable      (st.gen1_enable),
    .divider_sel (st.gen1_divider_sel),
    .range_sel   (st.gen1_range_sel),
    .duty        (st.gen1_duty),
    .pwm         (gen1_raw)
  );

  assign kind = frame_kind(frame_valid, frame_data[15:14]); // see (R17)
  assign addr = frame_data[13:8];
  assign wd   = frame_data[7:0];

  always_comb begin
    next_st        = st;
    next_st.clr    = '0;
    next_st.rvalid = 1'b0;
    // warning is sticky; set wins over nothing, read-only to host
    if (overtemp_event) begin
      next_st.overtemp_warning_flag = 1'b1; // see (R11)
    end
    unique case (kind)
      PRL_FR_WRITE: begin
        if (addr == `PRL_ADDR_LOCK) begin
          if (wd[7:5] == `PRL_LOCK_CODE) begin
            next_st.locked = 1'b1; // see (R8) (R9)
            next_st.lock   = wd[7:5];
          end else if (wd[7:5] == `PRL_UNLOCK_CODE) begin
            next_st.locked = 1'b0; // see (R10)
            next_st.lock   = wd[7:5];
          end
          if (!st.locked) begin
            next_st.olmax = wd[1];
            next_st.slew  = wd[0]; // see (R13)
          end
        end else if (addr == `PRL_ADDR_CLR) begin
          next_st.clr = wd; // see (R16) (R8)
        end else if (!st.locked) begin // see (R8)
          if (pwm1_hit(addr)) begin
            next_st.gen1_divider_sel = frame_data[9:8];
            next_st.gen1_duty        = wd;
          end else if (addr == `PRL_ADDR_ROUTE) begin
            next_st.output_route_enable = wd; // see (R5)
          end else if (addr == `PRL_ADDR_GSEL) begin
            next_st.output_generator_sel = wd; // see (R6)
          end else if (addr == `PRL_ADDR_FPWM) begin
            next_st.gen1_range_sel = wd[3]; // see (R14)
            next_st.gen1_enable    = wd[1]; // see (R15)
          end
        end
      end
      PRL_FR_READ: begin
        next_st.rvalid = 1'b1;
        next_st.rdata  = {2'b01, addr, 8'h00};
        if (pwm1_hit(addr)) begin
          next_st.rdata[9:0] = {st.gen1_divider_sel, st.gen1_duty};
        end else if (addr == `PRL_ADDR_ROUTE) begin
          next_st.rdata[7:0] = st.output_route_enable;
        end else if (addr == `PRL_ADDR_GSEL) begin
          next_st.rdata[7:0] = st.output_generator_sel;
        end else if (addr == `PRL_ADDR_FPWM) begin
          next_st.rdata[7:0] = {4'h8, st.gen1_range_sel, 1'b0, st.gen1_enable, 1'b0};
        end else if (addr == `PRL_ADDR_LOCK) begin
          // reserved bits 4..3 read zero
          next_st.rdata[7:0] = {st.lock, 2'b00, st.overtemp_warning_flag, st.olmax, st.slew}; // see (R12) (R11)
        end
      end
      PRL_FR_IDLE, PRL_FR_BAD: begin
      end
    endcase
    // output needs route enable; select alone drives nothing
    next_st.act = st.output_route_enable; // see (R5) (R7)
    for (int i = 0; i < NOUT; i++) begin
      next_st.lvl[i] = st.output_route_enable[i] &
                       (st.output_generator_sel[i] ? gen1_raw : gen0_pwm); // see (R6) (R7)
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st                      <= '0;
      st.lock                 <= 3'(`PRL_LOCK_RST >> 5); // see (R18)
      st.gen1_divider_sel     <= 2'(`PRL_PWM1_RST >> 8);
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign read_data         = st.rdata;
  assign read_valid        = st.rvalid;
  assign output_pwm_active = st.act;
  assign output_pwm_level  = st.lvl;
  assign error_latch_clear = st.clr;
  assign slew_select       = st.slew;
  // generator output flop already clears while disabled
  assign gen1_pwm          = gen1_raw;

  lock_blocks_a: assert property (@(posedge clk) disable iff (rst)
    ce && st.locked && kind == PRL_FR_WRITE && addr == `PRL_ADDR_ROUTE |=> $stable(st.output_route_enable))
    else $error("locked write changed route"); // see (R8)
  no_false_lock_a: assert property (@(posedge clk) disable iff (rst)
    ce && !st.locked && kind == PRL_FR_WRITE && addr == `PRL_ADDR_LOCK && wd[7:5] != `PRL_LOCK_CODE
    |=> !st.locked) else $error("locked by wrong code"); // see (R9)
  unlock_code_a: assert property (@(posedge clk) disable iff (rst)
    ce && st.locked && kind == PRL_FR_WRITE && addr == `PRL_ADDR_LOCK |=>
    (st.locked == ($past(wd[7:5]) != `PRL_UNLOCK_CODE))) else $error("unlock mishandled"); // see (R10)
  route_gate_a: assert property (@(posedge clk) disable iff (rst)
    ce ##1 1'b1 |-> (output_pwm_level & ~$past(st.output_route_enable)) == '0)
    else $error("unrouted output driven"); // see (R5) (R7)
  clear_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ce && kind == PRL_FR_WRITE && addr == `PRL_ADDR_CLR |=> error_latch_clear == $past(wd) ##1 (!ce || error_latch_clear == '0))
    else $error("clear not a pulse"); // see (R16)
  otw_sticky_a: assert property (@(posedge clk) disable iff (rst)
    ce && overtemp_event |=> st.overtemp_warning_flag) else $error("warning not set"); // see (R11)
  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    read_valid && read_data[13:8] == `PRL_ADDR_LOCK |-> read_data[4:3] == 2'b00)
    else $error("reserved bits nonzero"); // see (R12)
  unlock_rst_a: assert property (@(posedge clk)
    $past(rst) |-> !st.locked && st.lock == `PRL_UNLOCK_CODE) else $error("not unlocked at reset"); // see (R18)
endmodule

//--- dv/prl_host.sv
// Purpose: host model issuing register frames
// Assumes: one frame for each go cycle
// Notes:   idle data toggles so stale frames never look valid
`timescale 1ns/10ps
`include "prl_consts.svh"
module prl_host (
  // bench side
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       wr,
  input  wire logic [5:0] addr,
  input  wire logic [9:0] data,
  // frame side
  output logic            frame_valid,
  output logic [15:0]     frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_data  = 16'h0000;
  end
  always @(negedge clk) begin
    frame_valid <= go;
    if (go) begin
      frame_data <= {wr ? 2'b10 : 2'b01, addr[5:2], (addr == `PRL_ADDR_PWM1) ? data[9:8] : addr[1:0],
                     data[7:0]};
    end else begin
      frame_data <= ~frame_data;
    end
  end
endmodule

//--- dv/pwm_routing_and_lock_tb_top.sv
// Purpose: random and corner checks of routing, lock and generator 1
// Assumes: ce held high, host model formats frames
// Notes:   generator duty measured over whole periods
`timescale 1ns/10ps
`include "prl_consts.svh"
module pwm_routing_and_lock_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        ot = 1'b0;
  logic        g0 = 1'b0;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [5:0]  ad = 6'h00;
  logic [9:0]  dt = 10'h000;
  logic        fv;
  logic        rv;
  logic        slew;
  logic        g1;
  logic [15:0] fd;
  logic [15:0] rdat;
  logic [7:0]  act;
  logic [7:0]  lvl;
  logic [7:0]  clr;
  logic [7:0]  r;
  logic [7:0]  s;
  logic [31:0] seed = 32'hd2c62acd;
  int          fails = 0;
  int          tests_run = 0;

  always #10 clk = ~clk;

  prl_host u_prl_host (.clk(clk), .go(go), .wr(wr), .addr(ad), .data(dt), .frame_valid(fv), .frame_data(fd));
  prl_top u_prl_top (.clk(clk), .rst(rst), .ce(ce), .frame_valid(fv), .frame_data(fd), .read_data(rdat),
    .read_valid(rv), .overtemp_event(ot), .gen0_pwm(g0), .output_pwm_active(act), .output_pwm_level(lvl),
    .error_latch_clear(clr), .slew_select(slew), .gen1_pwm(g1));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_lvl(logic [7:0] ro, logic [7:0] se, logic a, logic b);
    return (ro & ~se & {8{a}}) | (ro & se & {8{b}});
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic send(logic w, logic [5:0] a, logic [9:0] d);
    @(posedge clk);
    go = 1'b1;
    wr = w;
    ad = a;
    dt = d;
    @(posedge clk);
    go = 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic rd(logic [5:0] a, logic [7:0] e);
    logic seen;
    seen = 1'b0;
    send(1'b0, a, 10'h000);
    repeat (3) begin
      @(negedge clk);
      if (rv === 1'b1)
        seen = 1'b1;
    end
    check({15'h0000, seen}, 16'h0001);
    check(rdat, {2'b01, a, e});
  endtask

  // count generator 1 on-cycles over one period after one settling period
  task automatic meas(logic [9:0] cfg, int dv, int duty);
    logic [15:0] n;
    n = 16'h0000;
    send(1'b1, `PRL_ADDR_PWM1, cfg);
    repeat (256 * dv) @(negedge clk);
    repeat (256 * dv) begin
      @(negedge clk);
      n = n + {15'h0000, g1};
    end
    check(n, 16'(duty * dv));
  endtask

  task automatic stop_test();
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(20 * 100000);
    fails++;
    stop_test();
  end

  initial begin
    logic [7:0] c;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    rd(`PRL_ADDR_LOCK, 8'h60);
    rd(`PRL_ADDR_ROUTE, 8'h00);
    rd(`PRL_ADDR_GSEL, 8'h00);
    rd(6'h3f, 8'h00);
    @(negedge clk);
    ot = 1'b1;
    @(negedge clk);
    ot = 1'b0;
    rd(`PRL_ADDR_LOCK, 8'h64);
    send(1'b1, `PRL_ADDR_FPWM, 10'h082);
    send(1'b1, `PRL_ADDR_PWM1, 10'h300);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 8'h00 : 8'(rnd());
      s = (i == 0) ? 8'hff : 8'(rnd());
      @(negedge clk);
      g0 = 1'(rnd());
      send(1'b1, `PRL_ADDR_ROUTE, {2'b00, r});
      send(1'b1, `PRL_ADDR_GSEL, {2'b00, s});
      settle();
      check({8'h00, act}, {8'h00, r});
      check({8'h00, lvl}, {8'h00, exp_lvl(r, s, g0, 1'b1)});
      rd(`PRL_ADDR_ROUTE, r);
    end
    send(1'b1, `PRL_ADDR_FPWM, 10'h080);
    settle();
    check({15'h0000, g1}, 16'h0000);
    // divider code 10 and duty 0 set before enabling so no leftover full-on cycle shows
    send(1'b1, `PRL_ADDR_PWM1, 10'h200);
    send(1'b1, `PRL_ADDR_FPWM, 10'h08a);
    c = 8'h00;
    repeat (600) begin
      @(negedge clk);
      c = c | {7'h00, g1};
    end
    check({8'h00, c}, 16'h0000);
    send(1'b1, `PRL_ADDR_LOCK, 10'h0c0);
    send(1'b1, `PRL_ADDR_ROUTE, 10'h05a);
    send(1'b1, `PRL_ADDR_LOCK, 10'h021);
    settle();
    check({8'h00, act}, {8'h00, r});
    rd(`PRL_ADDR_LOCK, 8'hc4);
    send(1'b1, `PRL_ADDR_CLR, 10'h0a5);
    c = 8'h00;
    repeat (3) begin
      @(negedge clk);
      c = c | clr;
    end
    check({8'h00, c}, 16'h00a5);
    send(1'b1, `PRL_ADDR_LOCK, 10'h060);
    send(1'b1, `PRL_ADDR_LOCK, 10'h041);
    send(1'b1, `PRL_ADDR_ROUTE, 10'h03c);
    settle();
    check({15'h0000, slew}, 16'h0001);
    check({8'h00, act}, 16'h003c);
    meas(10'h2ff, 51, 255);
    meas(10'h140, 64, 64);
    stop_test();
  end
endmodule
